// ===== bench/spi_master_model.sv
`timescale 1ns/10ps
module spi_master_model (
	// Serial link toward the slave.
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	// Serial data from the slave.
	input  wire logic miso
);
	localparam time HALF = 6ns;
	localparam time GAP  = 640ns;

	// idle low clock.
	// Driven late in the first time step so the slave's flops see the select edge.
	initial begin
		sclk <= 1'b0;
		cs_n <= 1'b1;
		mosi <= 1'b0;
	end

	task automatic select();
		#(7ns);
		cs_n = 1'b0;
		#(GAP);
	endtask

	task automatic deselect();
		#(HALF);
		cs_n = 1'b1;
		mosi = ~mosi;
		#(GAP);
	endtask

	// change on rise, sample on fall.
	task automatic word(input logic [15:0] tx, output logic [15:0] rx);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b1;
			mosi = tx[i];
			#(HALF);
			sclk = 1'b0;
			rx[i] = miso;
			#(HALF);
		end
		// The slave's hold has run out, so the line shows no stale bit.
		mosi = ~mosi;
		#(GAP);
	endtask
endmodule

// ===== bench/spi_slave_burst_bench.sv
`timescale 1ns/10ps
module spi_slave_burst_bench;
	logic        mclk;
	logic        rst_n;
	logic        sclk;
	logic        cs_n;
	logic        mosi;
	logic        miso;
	logic        miso_slew;
	logic        irq;
	logic        reg_wr;
	logic        reg_rd;
	logic [9:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [15:0] ans [0:31];
	logic [25:0] wq [$];
	int          miscompares;
	int          total_checks;
	localparam logic [15:0] CW = spi_burst_pkg::CHECK_WORD;
	localparam logic [9:0]  CA = spi_burst_pkg::CFG_ADDR;

	spi_slave_burst #(.WD_UNIT(4)) i_spi_slave_burst (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sclk      (sclk),
		.cs_n      (cs_n),
		.mosi      (mosi),
		.miso      (miso),
		.miso_slew (miso_slew),
		.irq       (irq),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_rdata (reg_rdata)
	);

	spi_master_model i_spi_master_model (
		.sclk (sclk),
		.cs_n (cs_n),
		.mosi (mosi),
		.miso (miso)
	);

	initial begin
		mclk = 1'b0;
	end
	always #20 mclk = ~mclk;

	// Register file stand-in: data depends on address, valid the cycle after a read.
	always @(posedge mclk) begin
		if (reg_rd === 1'b1) begin
			reg_rdata <= 16'ha800 | {6'h00, reg_addr};
		end
		if (reg_wr === 1'b1) begin
			wq.push_back({reg_addr, reg_wdata});
		end
	end

	task automatic wc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {15'h0000, e}, {15'h0000, g});
	endtask

	task automatic frame(input logic rd, input logic [9:0] adr, input logic [4:0] n,
			input logic [15:0] wd);
		i_spi_master_model.select();
		i_spi_master_model.word({rd, adr, n}, ans[0]);
		for (int i = 1; i <= n; i++) begin
			i_spi_master_model.word(rd ? 16'h0000 : wd + 16'(i - 1), ans[i]);
		end
		i_spi_master_model.deselect();
	endtask

	task automatic finish_test();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic t_reset();
		chk1("miso_slew", 1'b0, miso_slew);
		chk1("irq", 1'b0, irq);
		frame(1'b1, CA, 5'h01, 16'h0000);
		chk("ctl answer", CW, ans[0]);
		chk("cfg read", spi_burst_pkg::CFG_RESET, ans[1]);
		$display("test reset done");
	endtask

	task automatic t_write_max();
		logic [9:0] ea;
		wq.delete();
		frame(1'b0, 10'h3f0, 5'h1f, 16'h1000);
		wc(20);
		chk("wr count", 16'h001f, 16'(wq.size()));
		for (int i = 0; i < 31; i++) begin
			ea = 10'h3f0 + 10'(i);
			chk("wr addr", {6'h00, ea}, {6'h00, wq[i][25:16]});
			chk("wr data", 16'h1000 + 16'(i), wq[i][15:0]);
			chk("wr answer", CW, ans[i + 1]);
		end
		$display("test write_max done");
	endtask

	task automatic t_read();
		frame(1'b1, 10'h3fe, 5'h03, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			chk("rd data", 16'ha800 | {6'h00, 10'h3fe + 10'(i)}, ans[i + 1]);
		end
		$display("test read done");
	endtask

	task automatic t_gap_a();
		logic [15:0] r;
		wq.delete();
		i_spi_master_model.select();
		i_spi_master_model.word({1'b0, 10'h020, 5'h02}, r);
		i_spi_master_model.word(16'h0c01, r);
		// A gap of about 16 cycles stays inside the 44 cycle limit.
		i_spi_master_model.deselect();
		i_spi_master_model.select();
		i_spi_master_model.word(16'h0c02, r);
		i_spi_master_model.deselect();
		chk("gap writes", 16'h0002, 16'(wq.size()));
		chk("gap addr", 16'h0021, {6'h00, wq[1][25:16]});
		i_spi_master_model.select();
		i_spi_master_model.word({1'b0, 10'h020, 5'h02}, r);
		i_spi_master_model.word(16'h0c03, r);
		i_spi_master_model.deselect();
		wc(60);
		frame(1'b1, CA, 5'h01, 16'h0000);
		chk("gap frame err", CW | 16'h0002, ans[0]);
		$display("test gap_a done");
	endtask

	task automatic t_word_cfg();
		frame(1'b0, 10'h000, 5'h00, 16'h0000);
		wc(10);
		chk1("irq off", 1'b0, irq);
		frame(1'b1, CA, 5'h01, 16'h0000);
		chk("word err", CW | 16'h0001, ans[0]);
		frame(1'b0, CA, 5'h01, 16'hffca);
		wc(10);
		chk1("slew", 1'b1, miso_slew);
		frame(1'b1, CA, 5'h01, 16'h0000);
		chk("cfg back", 16'h01ca, ans[1]);
		frame(1'b0, 10'h000, 5'h00, 16'h0000);
		wc(10);
		chk1("irq on", 1'b1, irq);
		frame(1'b1, CA, 5'h01, 16'h0000);
		wc(10);
		chk1("irq clear", 1'b0, irq);
		$display("test word_cfg done");
	endtask

	task automatic t_mode_b();
		logic [15:0] r;
		i_spi_master_model.select();
		i_spi_master_model.word({1'b0, 10'h040, 5'h02}, r);
		i_spi_master_model.word(16'h0b01, r);
		i_spi_master_model.deselect();
		wc(10);
		chk1("irq frame", 1'b1, irq);
		frame(1'b1, CA, 5'h01, 16'h0000);
		chk("b frame err", CW | 16'h0002, ans[0]);
		$display("test mode_b done");
	endtask

	initial begin
		// Reset lands late in the first time step so the link flops see its edge.
		rst_n <= 1'b0;
		reg_rdata = 16'h0000;
		miscompares = 0;
		total_checks = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		wc(6);
		t_reset();
		t_write_max();
		t_read();
		t_gap_a();
		t_word_cfg();
		t_mode_b();
		finish_test();
	end

	initial begin
		repeat (25000) @(posedge mclk);
		miscompares++;
		$display("ERROR watchdog expected done seen timeout");
		finish_test();
	end
endmodule

// ===== hdl/spi_burst_pkg.sv
// Function
// RULE_01: Works only as serial slave; master supplies framing and clock.
// RULE_02: Clock phase 1, polarity 0; MOSI captured on falling serial clock edge.
// RULE_03: MISO bit updated on each rising serial clock edge.
// RULE_04: Idle-high clock masters need an external inverter on the clock line.
// RULE_05: Every serial word, control or data, is 16 bits.
// RULE_06: Control bit 15 set means read burst, clear means write burst.
// RULE_07: Control bits 14 to 5 give the burst start address.
// RULE_08: Control bits 4 to 0 give the number of data words.
// RULE_09: A burst holds at most 31 data words.
// RULE_10: After reset and each finished burst the next word is a control word.
// RULE_11: Write data goes to addressed registers; reads select the register data path.
// RULE_12: Protocol mode bit 0 selects mode A, 1 selects mode B.
// RULE_13: Every burst is checked by the rules of the current mode.
// RULE_14: With error interrupt enabled, a bad transmission raises the interrupt.
// RULE_15: Mode A chip select gap is limited to (watchdog+1)*32768 system clocks.
// RULE_16: One configuration bit selects the MISO edge rate.
// RULE_17: Host mode changes use frames valid in both modes, nonzero count, held select.
// RULE_18: A protocol mode change is accepted at any moment.
// RULE_19: A frame is 2 to 32 words, most significant bit first.
// RULE_20: Control word answer is check pattern plus clock, frame and word flags. The code ties the clock flag (bit 2) to 0.
// RULE_21: Write bursts return check pattern and flags for every data word.
// RULE_22: Read bursts return successive register contents while master sends zeros.
// RULE_23: The address advances by one after each data word.
// RULE_24: Chip select release ends the frame, except tolerated mode A gaps.
package spi_burst_pkg;
	localparam int          WORD_W      = 16;
	localparam int          ADDR_W      = 10;
	localparam int          CNT_W       = 5;
	localparam int          WD_W        = 21;
	localparam int          RW_BIT      = 15;
	localparam int          ADDR_HI     = 14;
	localparam int          ADDR_LO     = 5;
	localparam int          CNT_HI      = 4;
	localparam int          CNT_LO      = 0;
	localparam int          CFG_SLEW    = 8;
	localparam int          CFG_MODE    = 7;
	localparam int          CFG_IRQ     = 6;
	localparam int          CFG_WD_HI   = 4;
	localparam int          CFG_WD_LO   = 0;
	localparam int          CHK_LO      = 3;
	localparam int          WD_UNIT_DEF = 32768;
	localparam logic [ADDR_W-1:0] CFG_ADDR  = 10'h1c8;
	localparam logic [WORD_W-1:0] CFG_RESET = 16'h000a;
	localparam logic [WORD_W-1:0] CFG_MASK  = 16'h01ff;
	localparam logic [WORD_W-1:0] CHECK_WORD = 16'haaa8;
	localparam logic [CNT_W-1:0]  MAX_BURST = 5'h1f;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_ONE  = 10'h001;
	localparam logic [3:0]        BIT_FIRST = 4'h0;
	localparam logic [3:0]        BIT_LAST  = 4'hf;
	typedef enum logic [1:0] {
		ST_CTRL,
		ST_DATA,
		ST_GAP
	} proto_type;
endpackage

// ===== hdl/spi_link_shift.sv
`timescale 1ns/10ps
module spi_link_shift (
	// Serial link, clocked by the master.
	input  wire logic                              sclk,
	input  wire logic                              cs_n,
	input  wire logic                              rst_n,
	input  wire logic                              mosi,
	output logic                                   miso,
	// Word exchange with the system clock side.
	input  wire logic [spi_burst_pkg::WORD_W-1:0]  tx_word,
	output logic [spi_burst_pkg::WORD_W-1:0]       rx_word,
	output logic                                   word_tgl
);
	logic [3:0]                             cnt_r, cnt_nxt;
	logic [spi_burst_pkg::WORD_W-2:0]       rsh_r, rsh_nxt;
	logic [spi_burst_pkg::WORD_W-1:0]       rx_r, rx_nxt;
	logic                                   tgl_r, tgl_nxt;
	logic [spi_burst_pkg::WORD_W-2:0]       tsh_r, tsh_nxt;
	logic                                   miso_r, miso_nxt;

	// RULE_05 RULE_19 sixteen bits MSB first.
	always_comb begin
		cnt_nxt = cnt_r + 4'h1;
		rsh_nxt = {rsh_r[spi_burst_pkg::WORD_W-3:0], mosi};
		rx_nxt  = rx_r;
		tgl_nxt = tgl_r;
		if (cnt_r == spi_burst_pkg::BIT_LAST) begin
			rx_nxt  = {rsh_r, mosi};
			tgl_nxt = ~tgl_r;
		end
	end

	// Bit count restarts with each select; the clock is stopped then.
	// RULE_02 falling edge capture.
	// Reset clears the count as well, so a missed select edge cannot leave it unknown.
	always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 4'h0;
		end else if (cs_n) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// The toggle is never cleared by select, so no false word event appears.
	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			rsh_r <= 15'h0000;
			rx_r  <= 16'h0000;
			tgl_r <= 1'b0;
		end else begin
			rsh_r <= rsh_nxt;
			rx_r  <= rx_nxt;
			tgl_r <= tgl_nxt;
		end
	end

	// RULE_03 rising edge output.
	always_comb begin
		if (cnt_r == spi_burst_pkg::BIT_FIRST) begin
			miso_nxt = tx_word[spi_burst_pkg::WORD_W-1];
			tsh_nxt  = tx_word[spi_burst_pkg::WORD_W-2:0];
		end else begin
			miso_nxt = tsh_r[spi_burst_pkg::WORD_W-2];
			tsh_nxt  = {tsh_r[spi_burst_pkg::WORD_W-3:0], 1'b0};
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			miso_r <= 1'b0;
			tsh_r  <= 15'h0000;
		end else begin
			miso_r <= miso_nxt;
			tsh_r  <= tsh_nxt;
		end
	end

	assign miso     = miso_r;
	assign rx_word  = rx_r;
	assign word_tgl = tgl_r;
endmodule

// ===== hdl/spi_slave_burst.sv
`timescale 1ns/10ps
module spi_slave_burst #(
	parameter int WD_UNIT = spi_burst_pkg::WD_UNIT_DEF
) (
	// System clock and reset.
	input  wire logic                              mclk,
	input  wire logic                              rst_n,
	// Serial link pins.
	input  wire logic                              sclk,
	input  wire logic                              cs_n,
	input  wire logic                              mosi,
	output logic                                   miso,
	output logic                                   miso_slew,
	// Interrupt toward the host.
	output logic                                   irq,
	// Internal register path.
	output logic                                   reg_wr,
	output logic                                   reg_rd,
	output logic [spi_burst_pkg::ADDR_W-1:0]       reg_addr,
	output logic [spi_burst_pkg::WORD_W-1:0]       reg_wdata,
	input  wire logic [spi_burst_pkg::WORD_W-1:0]  reg_rdata
);
	logic [spi_burst_pkg::WORD_W-1:0] rx_word;
	logic                             word_tgl;
	logic                             tgl_s;
	logic                             cs_s;

	spi_burst_pkg::proto_type          st_r, st_nxt;
	logic                              rw_r, rw_nxt;
	logic [spi_burst_pkg::ADDR_W-1:0]  addr_r, addr_nxt;
	logic [spi_burst_pkg::CNT_W-1:0]   left_r, left_nxt;
	logic [spi_burst_pkg::WORD_W-1:0]  cfg_r, cfg_nxt;
	logic                              frame_err_r, frame_err_nxt;
	logic                              word_err_r, word_err_nxt;
	logic [spi_burst_pkg::WORD_W-1:0]  tx_r, tx_nxt;
	logic                              rd_pend_r, rd_pend_nxt;
	logic                              reg_wr_r, reg_wr_nxt;
	logic                              reg_rd_r, reg_rd_nxt;
	logic [spi_burst_pkg::ADDR_W-1:0]  reg_addr_r, reg_addr_nxt;
	logic [spi_burst_pkg::WORD_W-1:0]  reg_wdata_r, reg_wdata_nxt;
	logic                              irq_r, irq_nxt;
	logic [spi_burst_pkg::WD_W-1:0]    wd_cnt_r, wd_cnt_nxt;
	logic                              tgl_d_r, cs_d_r;
	logic                              word_evt, cs_rise, mode_b, reading;
	logic [spi_burst_pkg::WD_W-1:0]    wd_lim;
	logic [spi_burst_pkg::WORD_W-1:0]  status_word;

	// RULE_01 slave only link.
	spi_link_shift u_link (
		.sclk     (sclk),
		.cs_n     (cs_n),
		.rst_n    (rst_n),
		.mosi     (mosi),
		.miso     (miso),
		.tx_word  (tx_r),
		.rx_word  (rx_word),
		.word_tgl (word_tgl)
	);

	sync3 #(.RST_VAL(1'b0)) u_tgl_sync (
		.clk   (mclk),
		.rst_n (rst_n),
		.d     (word_tgl),
		.q     (tgl_s)
	);

	sync3 #(.RST_VAL(1'b1)) u_cs_sync (
		.clk   (mclk),
		.rst_n (rst_n),
		.d     (cs_n),
		.q     (cs_s)
	);

	// Select and toggle pass four register stages; the word itself waits for its toggle.
	// The received word is read only after its toggle has crossed, so it is stable.
	assign word_evt = tgl_s ^ tgl_d_r;
	assign cs_rise  = cs_s & ~cs_d_r;
	// RULE_12 mode select.
	assign mode_b   = cfg_r[spi_burst_pkg::CFG_MODE];
	assign reading  = (st_r != spi_burst_pkg::ST_CTRL) && rw_r;
	// The largest field times the default unit still fits in the counter width.
	// RULE_15 watchdog limit.
	assign wd_lim   = spi_burst_pkg::WD_W'({1'b0, cfg_r[spi_burst_pkg::CFG_WD_HI:
		spi_burst_pkg::CFG_WD_LO]} + 6'h01) * spi_burst_pkg::WD_W'(WD_UNIT);

	always_comb begin
		st_nxt        = st_r;
		rw_nxt        = rw_r;
		addr_nxt      = addr_r;
		left_nxt      = left_r;
		cfg_nxt       = cfg_r;
		frame_err_nxt = frame_err_r;
		word_err_nxt  = word_err_r;
		tx_nxt        = tx_r;
		rd_pend_nxt   = 1'b0;
		reg_wr_nxt    = 1'b0;
		reg_rd_nxt    = 1'b0;
		reg_addr_nxt  = reg_addr_r;
		reg_wdata_nxt = reg_wdata_r;
		wd_cnt_nxt    = wd_cnt_r;
		status_word   = 16'h0000;
		unique case (st_r)
			spi_burst_pkg::ST_CTRL: begin
				if (word_evt) begin
					// RULE_06 direction bit.
					rw_nxt        = rx_word[spi_burst_pkg::RW_BIT];
					// RULE_07 start address.
					addr_nxt      = rx_word[spi_burst_pkg::ADDR_HI:spi_burst_pkg::ADDR_LO];
					// RULE_08 word count.
					left_nxt      = rx_word[spi_burst_pkg::CNT_HI:spi_burst_pkg::CNT_LO];
					frame_err_nxt = 1'b0;
					word_err_nxt  = 1'b0;
					// RULE_09 count caps at 31.
					if (left_nxt > spi_burst_pkg::MAX_BURST) begin
						left_nxt = spi_burst_pkg::MAX_BURST;
					end
					// A zero count is refused as a word error and the frame stays waiting.
					if (left_nxt == 5'h00) begin
						word_err_nxt = 1'b1;
					end else begin
						st_nxt = spi_burst_pkg::ST_DATA;
						// RULE_11 read path prefetch.
						if (rw_nxt) begin
							reg_rd_nxt   = 1'b1;
							reg_addr_nxt = addr_nxt;
						end
					end
				end
			end
			spi_burst_pkg::ST_DATA: begin
				if (word_evt) begin
					if (!rw_r) begin
						// RULE_11 write delivery.
						if (addr_r == spi_burst_pkg::CFG_ADDR) begin
							// RULE_18 mode change takes effect at once.
							cfg_nxt = rx_word & spi_burst_pkg::CFG_MASK;
						end else begin
							reg_wr_nxt    = 1'b1;
							reg_addr_nxt  = addr_r;
							reg_wdata_nxt = rx_word;
						end
					end
					// RULE_23 address step.
					addr_nxt = addr_r + spi_burst_pkg::ADDR_ONE;
					left_nxt = left_r - spi_burst_pkg::CNT_ONE;
					// RULE_10 back to control word.
					if (left_r == spi_burst_pkg::CNT_ONE) begin
						st_nxt = spi_burst_pkg::ST_CTRL;
					end else if (rw_r) begin
						// RULE_22 next register content.
						reg_rd_nxt   = 1'b1;
						reg_addr_nxt = addr_nxt;
					end
				end else if (cs_rise) begin
					// RULE_13 mode B needs select held.
					// RULE_24 select release ends frame.
					if (mode_b) begin
						frame_err_nxt = 1'b1;
						st_nxt        = spi_burst_pkg::ST_CTRL;
					end else begin
						wd_cnt_nxt = 21'h00_0000;
						st_nxt     = spi_burst_pkg::ST_GAP;
					end
				end
			end
			spi_burst_pkg::ST_GAP: begin
				if (!cs_s) begin
					st_nxt = spi_burst_pkg::ST_DATA;
				end else if (mode_b) begin
					frame_err_nxt = 1'b1;
					st_nxt        = spi_burst_pkg::ST_CTRL;
				end else if (wd_cnt_r >= wd_lim) begin
					// RULE_15 gap too long.
					frame_err_nxt = 1'b1;
					st_nxt        = spi_burst_pkg::ST_CTRL;
				end else begin
					wd_cnt_nxt = wd_cnt_r + 21'h00_0001;
				end
			end
		endcase
		// RULE_20 check pattern and flags.
		status_word = {spi_burst_pkg::CHECK_WORD[spi_burst_pkg::WORD_W-1:spi_burst_pkg::CHK_LO],
			1'b0, frame_err_nxt, word_err_nxt};
		// The answer word changes only between words, while the link does not read it.
		// A master that shortens the gap between words gets the previous answer.
		if (rd_pend_r) begin
			// RULE_22 register content out.
			tx_nxt = (reg_addr_r == spi_burst_pkg::CFG_ADDR) ? cfg_r : reg_rdata;
		end else if (!reading) begin
			// RULE_21 status on write words.
			tx_nxt = status_word;
		end
		rd_pend_nxt = reg_rd_r;
		// RULE_14 error interrupt.
		irq_nxt = cfg_r[spi_burst_pkg::CFG_IRQ] & (frame_err_nxt | word_err_nxt);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_r        <= spi_burst_pkg::ST_CTRL;
			rw_r        <= 1'b0;
			addr_r      <= 10'h000;
			left_r      <= 5'h00;
			cfg_r       <= spi_burst_pkg::CFG_RESET;
			frame_err_r <= 1'b0;
			word_err_r  <= 1'b0;
			tx_r        <= spi_burst_pkg::CHECK_WORD;
			rd_pend_r   <= 1'b0;
			reg_wr_r    <= 1'b0;
			reg_rd_r    <= 1'b0;
			reg_addr_r  <= 10'h000;
			reg_wdata_r <= 16'h0000;
			irq_r       <= 1'b0;
			wd_cnt_r    <= 21'h00_0000;
			tgl_d_r     <= 1'b0;
			cs_d_r      <= 1'b1;
		end else begin
			st_r        <= st_nxt;
			rw_r        <= rw_nxt;
			addr_r      <= addr_nxt;
			left_r      <= left_nxt;
			cfg_r       <= cfg_nxt;
			frame_err_r <= frame_err_nxt;
			word_err_r  <= word_err_nxt;
			tx_r        <= tx_nxt;
			rd_pend_r   <= rd_pend_nxt;
			reg_wr_r    <= reg_wr_nxt;
			reg_rd_r    <= reg_rd_nxt;
			reg_addr_r  <= reg_addr_nxt;
			reg_wdata_r <= reg_wdata_nxt;
			irq_r       <= irq_nxt;
			wd_cnt_r    <= wd_cnt_nxt;
			tgl_d_r     <= tgl_s;
			cs_d_r      <= cs_s;
		end
	end

	// RULE_16 edge rate select.
	assign miso_slew = cfg_r[spi_burst_pkg::CFG_SLEW];
	assign irq       = irq_r;
	assign reg_wr    = reg_wr_r;
	assign reg_rd    = reg_rd_r;
	assign reg_addr  = reg_addr_r;
	assign reg_wdata = reg_wdata_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	ctrl_to_data_a: assert property (word_evt && st_r == spi_burst_pkg::ST_CTRL // RULE_08
		&& rx_word[4:0] != 5'h00 |=> st_r == spi_burst_pkg::ST_DATA)
		else $error("control word with count did not open a burst");
	dir_capture_a: assert property (word_evt && st_r == spi_burst_pkg::ST_CTRL // RULE_06
		|=> rw_r == $past(rx_word[15]))
		else $error("direction bit not taken");
	addr_capture_a: assert property (word_evt && st_r == spi_burst_pkg::ST_CTRL // RULE_07
		|=> addr_r == $past(rx_word[14:5]))
		else $error("start address not taken");
	write_path_a: assert property (word_evt && st_r == spi_burst_pkg::ST_DATA && !rw_r // RULE_11
		&& addr_r != spi_burst_pkg::CFG_ADDR |=> reg_wr && reg_wdata == $past(rx_word))
		else $error("write data not delivered");
	addr_step_a: assert property (word_evt && st_r == spi_burst_pkg::ST_DATA // RULE_23
		|=> addr_r == $past(addr_r) + 10'h001)
		else $error("address did not advance");
	burst_end_a: assert property (word_evt && st_r == spi_burst_pkg::ST_DATA // RULE_10
		&& left_r == 5'h01 |=> st_r == spi_burst_pkg::ST_CTRL)
		else $error("burst did not end after last word");
	modeb_release_a: assert property (st_r == spi_burst_pkg::ST_DATA && !word_evt // RULE_13
		&& cs_rise && mode_b |=> frame_err_r && st_r == spi_burst_pkg::ST_CTRL)
		else $error("mode B select release not flagged");
	gap_timeout_a: assert property (st_r == spi_burst_pkg::ST_GAP && cs_s && !mode_b // RULE_15
		&& wd_cnt_r >= wd_lim |=> frame_err_r)
		else $error("watchdog gap not flagged");
	irq_raise_a: assert property ($rose(frame_err_r) // RULE_14
		&& cfg_r[spi_burst_pkg::CFG_IRQ] |-> irq_r)
		else $error("error did not raise interrupt");
	read_data_a: assert property (reg_rd && reg_addr != spi_burst_pkg::CFG_ADDR // RULE_22
		|=> ##1 tx_r == $past(reg_rdata))
		else $error("read data not presented");
	status_pattern_a: assert property (!reading && !rd_pend_r |=> // RULE_20
		tx_r[spi_burst_pkg::WORD_W-1:spi_burst_pkg::CHK_LO] ==
		spi_burst_pkg::CHECK_WORD[spi_burst_pkg::WORD_W-1:spi_burst_pkg::CHK_LO]
		&& !tx_r[spi_burst_pkg::CHK_LO-1])
		else $error("status pattern not returned");
	count_zero_a: assert property (word_evt && st_r == spi_burst_pkg::ST_CTRL // RULE_19
		&& rx_word[spi_burst_pkg::CNT_HI:spi_burst_pkg::CNT_LO] == 5'h00
		|=> word_err_r && st_r == spi_burst_pkg::ST_CTRL)
		else $error("zero count not refused");
	cfg_write_a: assert property (word_evt && st_r == spi_burst_pkg::ST_DATA && !rw_r // RULE_18
		&& addr_r == spi_burst_pkg::CFG_ADDR
		|=> cfg_r == ($past(rx_word) & spi_burst_pkg::CFG_MASK))
		else $error("configuration write not taken");
	cfg_read_a: assert property (rd_pend_r && reg_addr_r == spi_burst_pkg::CFG_ADDR // RULE_22
		|=> tx_r == $past(cfg_r))
		else $error("configuration read not presented");
	word_irq_a: assert property ($rose(word_err_r) // RULE_14
		&& cfg_r[spi_burst_pkg::CFG_IRQ] |-> irq_r)
		else $error("word error did not raise interrupt");

	read_burst_c: cover property (st_r == spi_burst_pkg::ST_DATA && rw_r && word_evt);
	write_burst_c: cover property (reg_wr ##[1:200] st_r == spi_burst_pkg::ST_CTRL);
	gap_resume_c: cover property (st_r == spi_burst_pkg::ST_GAP ##1 st_r == spi_burst_pkg::ST_DATA);
	frame_err_c: cover property ($rose(frame_err_r));
	word_err_c: cover property ($rose(word_err_r));
endmodule

// ===== hdl/sync3.sv
`timescale 1ns/10ps
module sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Asynchronous level in, filtered level out.
	input  wire logic d,
	output logic      q
);
	logic ff1_r, ff2_r, ff3_r, q_r;
	logic ff1_nxt, ff2_nxt, ff3_nxt, q_nxt;

	// A change is taken only once the second and third stages agree.
	always_comb begin
		ff1_nxt = d;
		ff2_nxt = ff1_r;
		ff3_nxt = ff2_r;
		q_nxt   = (ff2_r == ff3_r) ? ff3_r : q_r;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ff1_r <= RST_VAL;
			ff2_r <= RST_VAL;
			ff3_r <= RST_VAL;
			q_r   <= RST_VAL;
		end else begin
			ff1_r <= ff1_nxt;
			ff2_r <= ff2_nxt;
			ff3_r <= ff3_nxt;
			q_r   <= q_nxt;
		end
	end

	assign q = q_r;
endmodule
